/* File: shared/sgoc_cfg.svh */
`ifndef SGOC_CFG_SVH
`define SGOC_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SGOC_A_CTRL 8'h00
`define SGOC_A_CMD 8'h04
`define SGOC_A_STAT 8'h08
`define SGOC_A_OPEN_CNT 8'h0c
`define SGOC_A_CLOSE_CNT 8'h10
`define SGOC_A_OPEN_FAIL 8'h14
`define SGOC_A_CLOSE_FAIL 8'h18
`define SGOC_A_GROUP_EN 8'h1c
`define SGOC_A_GROUP_REQ 8'h20
`define SGOC_A_EVT_MASK 8'h24
`define SGOC_A_PULSE_MAX 8'h28
`define SGOC_A_TIMEOUT 8'h2c
`define SGOC_A_TRAVERSE 8'h30
`define SGOC_A_GROUP_SRC 8'h34
`define SGOC_A_IO_MAP 8'h38
// ****************************************
// Reset values
// ****************************************
`define SGOC_GROUP_EN_RST 8'h01
`define SGOC_PULSE_RST 16'h0fa0
`define SGOC_TIMEOUT_RST 16'h9c40
`define SGOC_TRAVERSE_RST 16'h07d0
`define SGOC_IO_MAP_RST 32'h0001_3210
// ****************************************
// Pin slots in the synchroniser
// ****************************************
`define SGOC_PIN_LOC_OPEN 4
`define SGOC_PIN_LOC_CLOSE 5
`define SGOC_PIN_READY 6
`define SGOC_PIN_SYNC 7
`endif

/* File: shared/sgoc_pkg.sv */
package sgoc_pkg;
	// Decoded switchgear position
	typedef enum logic [1:0] {SGOC_POS_MID, SGOC_POS_OPEN, SGOC_POS_CLOSED,
		SGOC_POS_BAD} sgoc_pos_t;
	// Kind of controlled object
	typedef enum logic [1:0] {SGOC_OBJ_GND_DISC, SGOC_OBJ_MOTOR_DISC,
		SGOC_OBJ_BREAKER, SGOC_OBJ_WD_BREAKER} sgoc_obj_type_t;
	// Command sequencer states
	typedef enum logic [1:0] {SGOC_ST_IDLE, SGOC_ST_PULSE,
		SGOC_ST_WAIT} sgoc_ctl_state_t;
	// Control register
	typedef struct packed {
		logic [22:0] pad;
		logic remote_group_permit;
		logic forced_group_change_permit;
		logic pulse_only;
		sgoc_obj_type_t obj_type;
		logic ready_use;
		logic sync_use;
		logic remote;
		logic obj_enable;
	} sgoc_ctrl_t;
	// Command register, write-only strobes
	typedef struct packed {
		logic [28:0] pad;
		logic clear_stats;
		logic close;
		logic open;
	} sgoc_cmd_t;
	// Group change requests
	typedef struct packed {
		logic [23:0] pad;
		logic remote_req;
		logic [2:0] remote_grp;
		logic force_req;
		logic [2:0] force_grp;
	} sgoc_grp_req_t;
	// Feedback and output assignment
	typedef struct packed {
		logic [9:0] pad;
		logic [2:0] close_out;
		logic [2:0] open_out;
		logic [3:0] cart_out_src;
		logic [3:0] cart_in_src;
		logic [3:0] closed_src;
		logic [3:0] open_src;
	} sgoc_io_map_t;
	// Selectable signal sources
	typedef struct packed {
		logic zero;
		logic block;
		logic trip;
		logic start;
		logic obj_closed;
		logic obj_open;
		logic [1:0] temperature_sensor_alarm;
		logic [3:0] logic_sig;
		logic [3:0] dig;
	} sgoc_src_t;
	// One-hot decode of a 3-bit index
	function automatic logic [7:0] sgoc_onehot(input logic [2:0] i);
		sgoc_onehot = 8'h01 << i;
	endfunction
	// Pick one source bit
	function automatic logic sgoc_pick(input sgoc_src_t v, input logic [3:0] i);
		sgoc_pick = v[i];
	endfunction
endpackage

/* File: logic/sgoc_status_decoder.sv */
`timescale 1ns/100ps
module sgoc_status_decoder
	import sgoc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Feedback contacts and gap tolerance
	input wire logic open_fb,
	input wire logic closed_fb,
	input wire logic [15:0] traverse,
	// Decoded position
	output sgoc_pos_t pos
);
	// State: position and gap timer
	typedef struct packed {
		sgoc_pos_t pos;
		logic [15:0] gap_t;
	} sgoc_dec_state_t;
	sgoc_dec_state_t s;
	sgoc_dec_state_t next_s;

	// ****************************************
	// Decode
	// ****************************************
	// Gap between contacts is held for the traverse time
	always_comb begin
		next_s = s;
		next_s.gap_t = 16'h0000;
		case ({open_fb, closed_fb})
			2'b11: next_s.pos = SGOC_POS_BAD;
			2'b10: next_s.pos = SGOC_POS_OPEN;
			2'b01: next_s.pos = SGOC_POS_CLOSED;
			default: begin
				// Both low: travelling or stuck
				if (s.gap_t >= traverse) begin
					next_s.pos = SGOC_POS_MID;
					next_s.gap_t = s.gap_t;
				end else begin
					next_s.gap_t = s.gap_t + 16'h0001;
				end
			end
		endcase
	end

	// Register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{pos: SGOC_POS_MID, gap_t: 16'h0000};
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign pos = s.pos;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_MID: assert property (ce && !open_fb && !closed_fb && s.gap_t >= traverse
		|=> pos == SGOC_POS_MID) else $error("gap not reported");
	AST_BAD: assert property (ce && open_fb && closed_fb
		|=> pos == SGOC_POS_BAD) else $error("both contacts not bad");
	AST_OPEN: assert property (ce && open_fb && !closed_fb
		|=> pos == SGOC_POS_OPEN) else $error("open not decoded");
endmodule

/* File: logic/sgoc_group_select.sv */
`timescale 1ns/100ps
module sgoc_group_select
	import sgoc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Configuration
	input wire logic [7:0] group_en,
	input wire logic [7:0] evt_mask,
	input wire logic pulse_only,
	input wire logic force_permit,
	input wire logic remote_permit,
	// Requests
	input wire logic [7:0] sel_levels,
	input wire sgoc_grp_req_t req,
	// Result
	output logic [2:0] active_group,
	output logic group_event
);
	// State: last levels, active group, event
	typedef struct packed {
		logic [7:0] prev;
		logic [2:0] active;
		logic event_p;
	} sgoc_grp_state_t;
	sgoc_grp_state_t s;
	sgoc_grp_state_t next_s;
	logic [7:0] loc_req;
	logic [7:0] all_req;

	// ****************************************
	// Priority selection
	// ****************************************
	// Lowest index wins; static levels only in mixed mode
	always_comb begin
		next_s = s;
		next_s.prev = sel_levels;
		next_s.event_p = 1'b0;
		loc_req = pulse_only ? (sel_levels & ~s.prev) : sel_levels;
		all_req = loc_req;
		if (req.force_req && force_permit) begin
			all_req = all_req | sgoc_onehot(req.force_grp);
		end
		if (req.remote_req && remote_permit) begin
			all_req = all_req | sgoc_onehot(req.remote_grp);
		end
		all_req = all_req & group_en;
		for (int g = 7; g >= 0; g--) begin
			if (all_req[g]) begin
				next_s.active = 3'(g);
			end
		end
		// Only events of groups set in evt_mask leave the block
		if (next_s.active != s.active) begin
			next_s.event_p = evt_mask[next_s.active];
		end
	end

	// Register the state; group 1 after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{prev: 8'h00, active: 3'h0, event_p: 1'b0};
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign active_group = s.active;
	assign group_event = s.event_p;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PRIO: assert property (ce && !pulse_only && sel_levels[0] && group_en[0]
		|=> active_group == 3'h0) else $error("group 1 lost priority");
	AST_FORCE: assert property (ce && !force_permit && !remote_permit
		&& (loc_req & group_en) == 8'h00 |=> $stable(active_group))
		else $error("group changed without request");
endmodule

/* File: logic/sgoc_top.sv */
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "sgoc_cfg.svh"
// Summary of operation
// - No contact asserted reports Intermittent
// - Both contacts asserted reports Bad
// - Local or remote authority, local default
// - Close needs sync permission and readiness
// - Count accepted open and close requests
// - Count requests ending without status change
// - Clear statistics zeroes all counters
// - Eight groups, only group 1 enabled after reset
// - Lowest numbered requested group wins
// - Forced change only while permitted
// - Remote group change only while permitted
// - Select inputs as pulses or mixed
// - Each group select has assignable source
// - Group events masked off after reset
// - Everything but group 1 disabled after reset
// - Object type selectable, breaker by default
// - Cart feedback for withdrawable, assignable inputs
// - Commands drive assigned digital outputs
// - Command pulse capped, cut on change
// - Timeout aborts and flags failed request
// - Contact gap tolerated for traverse time
module sgoc_top
	import sgoc_pkg::*;
(
	// Clock, reset, clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Field pins, asynchronous
	input wire logic [3:0] dig_in,
	input wire logic local_open_in,
	input wire logic local_close_in,
	input wire logic obj_ready_in,
	input wire logic sync_permit_in,
	// Same-clock internal signals
	input wire logic [3:0] logic_sig,
	input wire logic [1:0] temperature_sensor_alarm,
	input wire logic prot_start,
	input wire logic prot_trip,
	input wire logic prot_block,
	// Switchgear commands and events
	output logic [7:0] dig_out,
	output logic [2:0] active_group,
	output logic group_event,
	output logic req_fail_event
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] pin_meta; // First sync stage
		logic [7:0] pin_sync; // Second sync stage
		logic [1:0] loc_prev; // Local command edge memory
		sgoc_ctrl_t ctrl;
		logic [7:0] group_en;
		logic [7:0] evt_mask;
		sgoc_grp_req_t grp_req;
		logic [15:0] pulse_max;
		logic [15:0] timeout;
		logic [15:0] traverse;
		logic [31:0] group_src;
		sgoc_io_map_t io_map;
		logic [15:0] open_cnt;
		logic [15:0] close_cnt;
		logic [15:0] open_fail;
		logic [15:0] close_fail;
		sgoc_ctl_state_t fsm;
		logic closing; // Command in progress is a close
		logic [15:0] pulse_t;
		logic [15:0] wait_t;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] dig_out;
		logic req_fail_event;
	} sgoc_top_state_t;
	sgoc_top_state_t s;
	sgoc_top_state_t next_s;

	// Combinational helpers
	sgoc_src_t src;
	sgoc_cmd_t cmd;
	sgoc_pos_t obj_pos;
	sgoc_pos_t cart_pos;
	logic [7:0] sel_levels;
	logic wr_en;
	logic setup;
	logic loc_open_edge;
	logic loc_close_edge;
	logic req_open;
	logic req_close;
	logic close_ok;
	logic reached;
	logic clear;

	// ****************************************
	// Source selection
	// ****************************************
	// Digital inputs are read only after synchronisation
	always_comb begin
		src.zero = 1'b0;
		src.block = prot_block;
		src.trip = prot_trip;
		src.start = prot_start;
		src.obj_closed = (obj_pos == SGOC_POS_CLOSED);
		src.obj_open = (obj_pos == SGOC_POS_OPEN);
		src.temperature_sensor_alarm = temperature_sensor_alarm;
		src.logic_sig = logic_sig;
		src.dig = s.pin_sync[3:0];
	end

	// Each group has its own selector field
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gsel
			assign sel_levels[g] = sgoc_pick(src, s.group_src[4*g +: 4]);
		end
	endgenerate

	// ****************************************
	// Position decoders
	// ****************************************
	// Main contacts; feedback is routed from selectable sources
	sgoc_status_decoder u_obj_dec (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.open_fb(sgoc_pick(src, s.io_map.open_src)),
		.closed_fb(sgoc_pick(src, s.io_map.closed_src)),
		.traverse(s.traverse),
		.pos(obj_pos)
	);

	// Cart contacts; only meaningful for withdrawable type
	sgoc_status_decoder u_cart_dec (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.open_fb(sgoc_pick(src, s.io_map.cart_out_src)),
		.closed_fb(sgoc_pick(src, s.io_map.cart_in_src)),
		.traverse(s.traverse),
		.pos(cart_pos)
	);

	// ****************************************
	// Setting groups
	// ****************************************
	sgoc_group_select u_grp (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.group_en(s.group_en),
		.evt_mask(s.evt_mask),
		.pulse_only(s.ctrl.pulse_only),
		.force_permit(s.ctrl.forced_group_change_permit),
		.remote_permit(s.ctrl.remote_group_permit),
		.sel_levels(sel_levels),
		.req(s.grp_req),
		.active_group(active_group),
		.group_event(group_event)
	);

	// ****************************************
	// Next state
	// ****************************************
	// Bus access, command sequencing and statistics
	always_comb begin
		next_s = s;
		cmd = sgoc_cmd_t'(pwdata);
		setup = psel && !penable;
		wr_en = psel && penable && s.pready && pwrite;
		// Pins pass two flops before use
		next_s.pin_meta = {sync_permit_in, obj_ready_in, local_close_in,
			local_open_in, dig_in};
		next_s.pin_sync = s.pin_meta;
		next_s.loc_prev = {s.pin_sync[`SGOC_PIN_LOC_CLOSE], s.pin_sync[`SGOC_PIN_LOC_OPEN]};
		loc_open_edge = s.pin_sync[`SGOC_PIN_LOC_OPEN] && !s.loc_prev[0];
		loc_close_edge = s.pin_sync[`SGOC_PIN_LOC_CLOSE] && !s.loc_prev[1];
		// Group requests act for one cycle
		next_s.grp_req.force_req = 1'b0;
		next_s.grp_req.remote_req = 1'b0;
		clear = 1'b0;
		req_open = 1'b0;
		req_close = 1'b0;
		// Register writes
		if (wr_en) begin
			case (paddr)
				`SGOC_A_CTRL: next_s.ctrl = sgoc_ctrl_t'(pwdata);
				`SGOC_A_CMD: begin
					// Bus open and close commands only count in remote mode
					req_open = cmd.open && s.ctrl.remote;
					req_close = cmd.close && s.ctrl.remote;
					clear = cmd.clear_stats;
				end
				`SGOC_A_GROUP_EN: next_s.group_en = pwdata[7:0];
				`SGOC_A_GROUP_REQ: next_s.grp_req = sgoc_grp_req_t'(pwdata);
				`SGOC_A_EVT_MASK: next_s.evt_mask = pwdata[7:0];
				`SGOC_A_PULSE_MAX: next_s.pulse_max = pwdata[15:0];
				`SGOC_A_TIMEOUT: next_s.timeout = pwdata[15:0];
				`SGOC_A_TRAVERSE: next_s.traverse = pwdata[15:0];
				`SGOC_A_GROUP_SRC: next_s.group_src = pwdata;
				`SGOC_A_IO_MAP: next_s.io_map = sgoc_io_map_t'(pwdata);
				default: next_s.ctrl = s.ctrl;
			endcase
		end
		// Local inputs only count in local mode
		if (!s.ctrl.remote) begin
			req_open = loc_open_edge;
			req_close = loc_close_edge;
		end
		// Close interlocks
		close_ok = (!s.ctrl.sync_use || s.pin_sync[`SGOC_PIN_SYNC])
			&& (!s.ctrl.ready_use || s.pin_sync[`SGOC_PIN_READY]);
		reached = s.closing ? (obj_pos == SGOC_POS_CLOSED) : (obj_pos == SGOC_POS_OPEN);
		// Clear first so a same-cycle count survives
		if (clear) begin
			next_s.open_cnt = 16'h0000;
			next_s.close_cnt = 16'h0000;
			next_s.open_fail = 16'h0000;
			next_s.close_fail = 16'h0000;
		end
		next_s.req_fail_event = 1'b0;
		next_s.pulse_t = s.pulse_t + 16'h0001;
		next_s.wait_t = s.wait_t + 16'h0001;
		case (s.fsm)
			SGOC_ST_IDLE: begin
				// Disabled object ignores open and close commands; open wins a tie
				if (s.ctrl.obj_enable && req_open) begin
					next_s.fsm = SGOC_ST_PULSE;
					next_s.closing = 1'b0;
					next_s.open_cnt = next_s.open_cnt + 16'h0001;
				end else if (s.ctrl.obj_enable && req_close && close_ok) begin
					next_s.fsm = SGOC_ST_PULSE;
					next_s.closing = 1'b1;
					next_s.close_cnt = next_s.close_cnt + 16'h0001;
				end
				next_s.pulse_t = 16'h0001;
				next_s.wait_t = 16'h0001;
			end
			SGOC_ST_PULSE, SGOC_ST_WAIT: begin
				if (reached) begin
					next_s.fsm = SGOC_ST_IDLE;
				end else if (s.wait_t >= s.timeout) begin
					// Give up; status never followed the command
					next_s.fsm = SGOC_ST_IDLE;
					next_s.req_fail_event = 1'b1;
					if (s.closing) begin
						next_s.close_fail = next_s.close_fail + 16'h0001;
					end else begin
						next_s.open_fail = next_s.open_fail + 16'h0001;
					end
				end else if (s.pulse_t >= s.pulse_max) begin
					next_s.fsm = SGOC_ST_WAIT;
				end
			end
			default: next_s.fsm = SGOC_ST_IDLE;
		endcase
		// Command output follows the pulse state
		next_s.dig_out = 8'h00;
		if (next_s.fsm == SGOC_ST_PULSE) begin
			next_s.dig_out = sgoc_onehot(next_s.closing ? s.io_map.close_out :
				s.io_map.open_out);
		end
		// APB: data latched in setup, ready in access phase
		next_s.pready = setup;
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h0000_0000;
		if (setup) begin
			case (paddr)
				`SGOC_A_CTRL: next_s.prdata = s.ctrl;
				`SGOC_A_CMD: next_s.prdata = 32'h0000_0000;
				`SGOC_A_STAT: next_s.prdata = {22'h00_0000, active_group, s.fsm,
					(s.ctrl.obj_type == SGOC_OBJ_WD_BREAKER) ? cart_pos : SGOC_POS_MID,
					obj_pos, 1'b0};
				`SGOC_A_OPEN_CNT: next_s.prdata = {16'h0000, s.open_cnt};
				`SGOC_A_CLOSE_CNT: next_s.prdata = {16'h0000, s.close_cnt};
				`SGOC_A_OPEN_FAIL: next_s.prdata = {16'h0000, s.open_fail};
				`SGOC_A_CLOSE_FAIL: next_s.prdata = {16'h0000, s.close_fail};
				`SGOC_A_GROUP_EN: next_s.prdata = {24'h00_0000, s.group_en};
				`SGOC_A_GROUP_REQ: next_s.prdata = s.grp_req;
				`SGOC_A_EVT_MASK: next_s.prdata = {24'h00_0000, s.evt_mask};
				`SGOC_A_PULSE_MAX: next_s.prdata = {16'h0000, s.pulse_max};
				`SGOC_A_TIMEOUT: next_s.prdata = {16'h0000, s.timeout};
				`SGOC_A_TRAVERSE: next_s.prdata = {16'h0000, s.traverse};
				`SGOC_A_GROUP_SRC: next_s.prdata = s.group_src;
				`SGOC_A_IO_MAP: next_s.prdata = s.io_map;
				default: next_s.pslverr = 1'b1;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// All but group 1 disabled, local, breaker type, events masked at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.ctrl.obj_type <= SGOC_OBJ_BREAKER;
			s.group_en <= `SGOC_GROUP_EN_RST;
			s.pulse_max <= `SGOC_PULSE_RST;
			s.timeout <= `SGOC_TIMEOUT_RST;
			s.traverse <= `SGOC_TRAVERSE_RST;
			s.io_map <= `SGOC_IO_MAP_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign dig_out = s.dig_out;
	assign req_fail_event = s.req_fail_event;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_LOCAL: assert property (ce && s.fsm == SGOC_ST_IDLE && !s.ctrl.remote
		&& !loc_open_edge && !loc_close_edge |=> s.fsm == SGOC_ST_IDLE)
		else $error("command taken without local edge");
	AST_SYNC: assert property (ce && s.fsm == SGOC_ST_IDLE && s.ctrl.sync_use
		&& !s.pin_sync[`SGOC_PIN_SYNC] |=> !(s.fsm == SGOC_ST_PULSE && s.closing))
		else $error("close without permission");
	AST_CNT: assert property (ce && s.fsm == SGOC_ST_IDLE && next_s.fsm == SGOC_ST_PULSE
		&& !next_s.closing && !clear |=> s.open_cnt == $past(s.open_cnt) + 16'h0001)
		else $error("open request not counted");
	// A request accepted with the clear survives it, so only that case is exempt
	AST_CLR: assert property (ce && clear
		&& !(s.fsm == SGOC_ST_IDLE && next_s.fsm == SGOC_ST_PULSE)
		|=> s.open_cnt == 16'h0000 && s.close_cnt == 16'h0000)
		else $error("statistics not cleared");
	AST_PULSE: assert property (s.dig_out != 8'h00 |-> s.fsm == SGOC_ST_PULSE
		&& (s.pulse_t <= s.pulse_max || s.pulse_max == 16'h0000))
		else $error("command pulse too long");
	AST_FAIL: assert property (ce && s.fsm != SGOC_ST_IDLE && s.wait_t >= s.timeout
		&& !reached |=> s.req_fail_event && s.fsm == SGOC_ST_IDLE)
		else $error("timeout not flagged");
	COV_CLOSE: cover property (ce && s.fsm == SGOC_ST_IDLE && next_s.closing
		&& next_s.fsm == SGOC_ST_PULSE);
	COV_FAIL: cover property (s.req_fail_event);
	COV_GROUP: cover property (group_event);
endmodule

/* File: tb/sgoc_gear_model.sv */
`timescale 1ns/100ps
module sgoc_gear_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command outputs and fault switch
	input wire logic [7:0] cmd,
	input wire logic stuck,
	// Contacts: [0] open, [1] closed, [2] cart in, [3] cart out
	output logic [3:0] fb
);
	// Travel countdown and target
	logic [2:0] t;
	logic tgt;
	// Both contacts drop while moving, so the decoder must ride the gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb <= 4'h5;
			t <= 3'h0;
			tgt <= 1'b0;
		end else if (t != 3'h0) begin
			t <= t - 3'h1;
			if (t == 3'h1)
				fb <= {2'b01, tgt, !tgt};
		end else if (!stuck && ((cmd[0] && !fb[1]) || (cmd[1] && !fb[0]))) begin
			tgt <= cmd[0];
			t <= 3'h2;
			fb <= 4'h4;
		end
	end
endmodule

/* File: tb/sgoc_tb_top.sv */
`timescale 1ns/100ps
`include "sgoc_cfg.svh"
module sgoc_tb_top;
	// ****************
	// Pins and tallies
	// ****************
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic local_open_in = 1'b0, local_close_in = 1'b0, stuck = 1'b0;
	logic obj_ready_in = 1'b0, sync_permit_in = 1'b0;
	logic pready, pslverr, group_event, req_fail_event, err;
	logic [7:0] paddr = 8'h00, dig_out, last = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0] dig_in, logic_sig = 4'h0;
	logic [2:0] active_group;
	int mismatches = 0, n_compared = 0, pl = 0, ev = 0, b, n;
	// Bus clock
	always #12.5 pclk = ~pclk;
	sgoc_top dut(.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .dig_in, .local_open_in,
		.local_close_in, .obj_ready_in, .sync_permit_in, .logic_sig,
		.temperature_sensor_alarm(2'h0), .prot_start(1'b0), .prot_trip(1'b0),
		.prot_block(1'b0), .dig_out, .active_group, .group_event, .req_fail_event);
	sgoc_gear_model gear(.pclk, .presetn, .cmd(dig_out), .stuck, .fb(dig_in));
	// Pulse length, last command, group events
	always @(posedge pclk) begin
		if (dig_out !== 8'h00) begin
			pl <= pl + 1;
			last <= dig_out;
		end
		if (group_event === 1'b1)
			ev <= ev + 1;
	end
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// One transfer; an idle edge after it keeps drivers single per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, q, e);
	endtask
	// Decoded position field of the status word
	task automatic pos(input string s, input logic [1:0] e);
		apb(1'b0, `SGOC_A_STAT, 32'h0);
		chk(s, q[2:1], e);
	endtask
	task automatic loc(input logic o);
		if (o)
			local_open_in <= 1'b1;
		else
			local_close_in <= 1'b1;
		cyc(6);
		local_open_in <= 1'b0;
		local_close_in <= 1'b0;
		cyc(12);
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// Test sequence
	// ****************
	initial begin
		cyc(6);
		presetn <= 1'b1;
		cyc(1);
		rd("ctrl", `SGOC_A_CTRL, 32'h20);
		rd("group_en", `SGOC_A_GROUP_EN, 32'h1);
		rd("evt_mask", `SGOC_A_EVT_MASK, 32'h0);
		rd("unmapped", 8'hfc, 32'h0);
		chk("slverr", err, 1'b1);
		loc(1'b0);
		rd("close_cnt", `SGOC_A_CLOSE_CNT, 32'h0);
		$display("reset test done");
		wr(`SGOC_A_PULSE_MAX, 32'h8);
		wr(`SGOC_A_TIMEOUT, 32'h14);
		wr(`SGOC_A_TRAVERSE, 32'h3);
		wr(`SGOC_A_CTRL, 32'h21);
		b = pl;
		loc(1'b0);
		chk("close_out", last, 8'h01);
		chk("cut_short", pl - b < 8, 1'b1);
		pos("closed", 2'h2);
		rd("close_cnt", `SGOC_A_CLOSE_CNT, 32'h1);
		// Remote: local pin ignored, bus obeyed
		wr(`SGOC_A_CTRL, 32'h23);
		loc(1'b1);
		rd("open_cnt", `SGOC_A_OPEN_CNT, 32'h0);
		wr(`SGOC_A_CMD, 32'h1);
		cyc(12);
		chk("open_out", last, 8'h02);
		rd("open_cnt", `SGOC_A_OPEN_CNT, 32'h1);
		// Close interlocks: both missing, then readiness missing, then both present
		wr(`SGOC_A_CTRL, 32'h2f);
		wr(`SGOC_A_CMD, 32'h2);
		sync_permit_in <= 1'b1;
		cyc(12);
		wr(`SGOC_A_CMD, 32'h2);
		cyc(12);
		rd("close_cnt", `SGOC_A_CLOSE_CNT, 32'h1);
		obj_ready_in <= 1'b1;
		cyc(3);
		wr(`SGOC_A_CMD, 32'h2);
		cyc(12);
		rd("close_cnt", `SGOC_A_CLOSE_CNT, 32'h2);
		// Gear that never moves
		stuck <= 1'b1;
		b = pl;
		wr(`SGOC_A_CMD, 32'h1);
		n = 0;
		while (req_fail_event !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("fail_event", n < 40, 1'b1);
		cyc(1);
		chk("pulse_max", pl - b, 32'h8);
		rd("open_fail", `SGOC_A_OPEN_FAIL, 32'h1);
		wr(`SGOC_A_CMD, 32'h4);
		for (int i = 0; i < 4; i++)
			rd("counter", `SGOC_A_OPEN_CNT + 8'(4 * i), 32'h0);
		$display("object test done");
		// Contacts taken from logic_sig[1:0]
		wr(`SGOC_A_IO_MAP, 32'h13254);
		for (int i = 3; i > 0; i--) begin
			logic_sig <= 4'(i);
			cyc(4);
			pos("pos", 2'(i));
		end
		logic_sig <= 4'h0;
		pos("gap_hold", 2'h1);
		cyc(6);
		pos("gap_mid", 2'h0);
		chk("cart_hidden", q[4:3], 2'h0);
		wr(`SGOC_A_CTRL, 32'h3f);
		apb(1'b0, `SGOC_A_STAT, 32'h0);
		chk("cart_in", q[4:3], 2'h2);
		$display("decoder test done");
		// Groups 3 and 5 on logic_sig[2] and [3]
		wr(`SGOC_A_GROUP_SRC, 32'hfff7_f6ff);
		wr(`SGOC_A_GROUP_EN, 32'hff);
		wr(`SGOC_A_EVT_MASK, 32'h04);
		wr(`SGOC_A_GROUP_REQ, 32'h0c);
		cyc(4);
		chk("no_force", active_group, 3'h0);
		wr(`SGOC_A_CTRL, 32'ha1);
		wr(`SGOC_A_GROUP_EN, 32'h01);
		wr(`SGOC_A_GROUP_REQ, 32'h0c);
		cyc(4);
		chk("disabled", active_group, 3'h0);
		wr(`SGOC_A_GROUP_EN, 32'hff);
		wr(`SGOC_A_GROUP_REQ, 32'h0c);
		cyc(4);
		chk("forced", active_group, 3'h4);
		wr(`SGOC_A_GROUP_REQ, 32'h90);
		cyc(4);
		chk("no_remote", active_group, 3'h4);
		wr(`SGOC_A_CTRL, 32'h1a1);
		wr(`SGOC_A_GROUP_REQ, 32'h90);
		cyc(4);
		chk("remote", active_group, 3'h1);
		b = ev;
		logic_sig <= 4'h8;
		cyc(4);
		chk("level", active_group, 3'h4);
		logic_sig <= 4'hc;
		cyc(4);
		chk("lowest", active_group, 3'h2);
		chk("events", ev - b, 32'h1);
		wr(`SGOC_A_CTRL, 32'h1e1);
		logic_sig <= 4'h8;
		cyc(4);
		chk("no_edge", active_group, 3'h2);
		logic_sig <= 4'h0;
		cyc(2);
		logic_sig <= 4'h8;
		cyc(4);
		chk("edge", active_group, 3'h4);
		$display("group test done");
		finish_test;
	end
	// Watchdog
	initial begin
		cyc(4000);
		mismatches++;
		finish_test;
	end
endmodule
